// File: inc/emrf_pkg.sv
// Constants, register map and carrier types for the receive filter block.
// Assumes a 32-bit APB slave with 12-bit byte offsets inside the block window.
package emrf_pkg;
  // ==========================================================================
  // Register offsets (byte addresses inside the block)
  localparam logic [11:0] OFF_RXC1 = 12'h010;
  localparam logic [11:0] OFF_RXC2 = 12'h014;
  localparam logic [11:0] OFF_SEED = 12'h020;
  localparam logic [11:0] OFF_MASK = 12'h0A0;
  localparam logic [11:0] OFF_MATCH = 12'h0C0;
  localparam logic [11:0] OFF_THRESH = 12'h0E0;
  localparam logic [11:0] OFF_STATION = 12'h0F0;
  localparam logic [11:0] OFF_RXSTAT = 12'h180;
  localparam logic [11:0] OFF_CORE = 12'h1FC;
  // ==========================================================================
  // Field positions
  localparam int RXC1_EN = 0;
  localparam int RXC1_PADSTRIP = 1;
  localparam int RXC1_LOOP = 4;
  localparam int RXC1_FILT = 5;
  localparam int RXC1_RUNT_OK = 6;
  localparam int RXC1_BC_DIS = 7;
  localparam int CORE_MAC_RST = 0;
  localparam int CORE_RX_FLUSH = 1;
  localparam int CORE_TX_FLUSH = 2;
  localparam int CORE_JAM = 3;
  localparam int CORE_MDC_DRV = 4;
  localparam int DA_MSB = 47;
  // ==========================================================================
  // Reset values and frame figures
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_THRESH = 8'h01;
  localparam logic [7:0] RST_SEED = 8'h01;
  localparam logic [4:0] RST_CORE = 5'h00;
  localparam logic [10:0] MIN_FRAME = 11'h040;
  localparam logic [10:0] PAD_END = 11'h03C;
  localparam logic [10:0] HDR_LEN = 11'h00E;
  localparam logic [15:0] MIN_PAYLOAD = 16'h002E;
  localparam logic [15:0] MAX_LEN = 16'h05DC;
  localparam logic [15:0] MIN_TYPE = 16'h0600;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
  localparam logic [3:0] SFD_NIB = 4'hD;
  localparam logic [2:0] DA_BYTES = 3'h6;
  localparam int MDC_DIV = 32;
  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic sof;
    logic [7:0] data;
  } emrf_byte_t;
  typedef struct packed {
    logic accept;
    logic addr_drop;
    logic runt;
    logic bad_type;
    logic fcs_err;
    logic flushed;
  } emrf_status_t;
endpackage : emrf_pkg

// File: logic/emrf_rx_filter.sv
// Receive qualification, coprocessor control and APB register file.
// Assumes MII pins asynchronous to clk_i and a PHY clock far slower than clk_i.
`timescale 1ns/100ps
// Function
// - Unicast must match station address when filtering
// - Masked match equals masked destination passes
// - Zero mask disables multicast filtering
// - Length/type captured only after filter pass
// - Strip pad of short frames when enabled
// - Runts forwarded or purged per control bit
// - Invalid type values purge the frame
// - Bad FCS frames discarded and purged
// - Pad bytes enter the FCS check
// - Status per frame sent to packet engine
// - Loopback routes transmit data into receive
// - Receiver runs only when enabled
// - MDC driven out only when selected
// - Jam request on new receive when enabled
// - Transmit FIFO flush while bit set
// - Receive flush discards frames while set
// - MAC held reset while bit set
// - Seed loads crossover selection LFSR
// - Filter bit off passes all non-broadcast
// - Broadcast drop needs three conditions
module emrf_rx_filter #(
  parameter int MDC_DIV_P = emrf_pkg::MDC_DIV // MDC half period in clk_i cycles
) (
  input wire logic clk_i, // 125 MHz clock
  input wire logic srst_i, // Synchronous reset, high
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [11:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error, always low
  input wire logic mii_rx_clk_i, // PHY receive clock
  input wire logic mii_rx_dv_i, // PHY receive data valid
  input wire logic [3:0] mii_rxd_i, // PHY receive nibble
  input wire logic tx_clk_i, // Transmit clock for loopback
  input wire logic tx_en_i, // Transmit enable for loopback
  input wire logic [3:0] txd_i, // Transmit nibble for loopback
  output emrf_pkg::emrf_byte_t pe_byte_o, // Byte to packet engine
  output logic pe_valid_o, // Byte valid pulse
  output emrf_pkg::emrf_status_t pe_status_o, // Frame status
  output logic pe_status_vld_o, // Status valid pulse
  output logic jam_o, // Jam request pulse
  output logic tx_flush_o, // Transmit FIFO flush level
  output logic rx_flush_o, // Receive FIFO flush level
  output logic mac_rst_o, // MAC soft reset level
  output logic mdc_o, // MDC clock out
  output logic mdc_oe_o, // MDC output enable
  output logic xover_sel_o // MDI(0)/MDI-X(1) start choice
);
  import emrf_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_DATA, ST_DROP} emrf_state_t;

  // ==========================================================================
  // Register file
  logic [7:0] rxc1_r, rxc2_r, seed_r, thresh_r;
  logic [4:0] core_r;
  logic [7:0] mask_r [6];
  logic [7:0] match_r [6];
  logic [7:0] station_r [6];
  logic [31:0] prdata_r;
  logic pready_r;
  emrf_status_t last_stat_r;

  wire apb_setup = psel_i & ~penable_i;
  wire apb_wr = psel_i & penable_i & pwrite_i & pready_r;
  wire [11:0] mk_off = paddr_i - OFF_MASK;
  wire [11:0] mt_off = paddr_i - OFF_MATCH;
  wire [11:0] st_off = paddr_i - OFF_STATION;
  wire mk_hit = (mk_off[11:5] == 7'h00) && (mk_off[1:0] == 2'h0) && (mk_off[4:2] < DA_BYTES);
  wire mt_hit = (mt_off[11:5] == 7'h00) && (mt_off[1:0] == 2'h0) && (mt_off[4:2] < DA_BYTES);
  wire st_hit = (st_off[11:5] == 7'h00) && (st_off[1:0] == 2'h0) && (st_off[4:2] < DA_BYTES);
  wire seed_wr = apb_wr && (paddr_i == OFF_SEED);

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (mk_hit) begin
      rd_mux = {24'h000000, mask_r[mk_off[4:2]]};
    end else if (mt_hit) begin
      rd_mux = {24'h000000, match_r[mt_off[4:2]]};
    end else if (st_hit) begin
      rd_mux = {24'h000000, station_r[st_off[4:2]]};
    end else begin
      case (paddr_i)
        OFF_RXC1: rd_mux = {24'h000000, rxc1_r};
        OFF_RXC2: rd_mux = {24'h000000, rxc2_r};
        OFF_SEED: rd_mux = {24'h000000, seed_r};
        OFF_THRESH: rd_mux = {24'h000000, thresh_r};
        OFF_CORE: rd_mux = {27'h0, core_r};
        OFF_RXSTAT: rd_mux = {26'h0, last_stat_r};
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  // Zero-wait slave: ready rises in the first access cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= apb_setup;
      if (apb_setup) begin
        prdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rxc1_r <= RST_BYTE;
      rxc2_r <= RST_BYTE;
      seed_r <= RST_SEED;
      thresh_r <= RST_THRESH;
      core_r <= RST_CORE;
    end else if (apb_wr) begin
      case (paddr_i)
        OFF_RXC1: rxc1_r <= pwdata_i[7:0];
        OFF_RXC2: rxc2_r <= pwdata_i[7:0]; // Kept zero by software
        OFF_SEED: seed_r <= pwdata_i[7:0];
        OFF_THRESH: thresh_r <= pwdata_i[7:0]; // Only 0x01 is meaningful
        OFF_CORE: core_r <= pwdata_i[4:0];
        default: ;
      endcase
    end
  end

  for (genvar g = 0; g < 6; g++) begin : g_addr
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        mask_r[g] <= RST_BYTE;
        match_r[g] <= RST_BYTE;
        station_r[g] <= RST_BYTE;
      end else if (apb_wr) begin
        if (mk_hit && (mk_off[4:2] == 3'(g))) begin
          mask_r[g] <= pwdata_i[7:0];
        end
        if (mt_hit && (mt_off[4:2] == 3'(g))) begin
          match_r[g] <= pwdata_i[7:0];
        end
        if (st_hit && (st_off[4:2] == 3'(g))) begin
          station_r[g] <= pwdata_i[7:0];
        end
      end
    end
  end

  // ==========================================================================
  // Coprocessor control outputs
  wire mac_rst = srst_i | core_r[CORE_MAC_RST];
  logic [15:0] mdc_cnt_r;
  logic mdc_r, mdc_oe_r, tx_flush_r, rx_flush_r, mac_rst_r;
  logic [7:0] lfsr_r;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mdc_cnt_r <= 16'h0000;
      mdc_r <= 1'b0;
      mdc_oe_r <= 1'b0;
      tx_flush_r <= 1'b0;
      rx_flush_r <= 1'b0;
      mac_rst_r <= 1'b0;
    end else begin
      mdc_oe_r <= core_r[CORE_MDC_DRV];
      tx_flush_r <= core_r[CORE_TX_FLUSH];
      rx_flush_r <= core_r[CORE_RX_FLUSH];
      mac_rst_r <= core_r[CORE_MAC_RST];
      if (mdc_cnt_r == 16'(MDC_DIV_P - 1)) begin
        mdc_cnt_r <= 16'h0000;
        mdc_r <= ~mdc_r;
      end else begin
        mdc_cnt_r <= mdc_cnt_r + 16'h0001;
      end
    end
  end

  // Seed reloads on every write so software can replay a start choice
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lfsr_r <= RST_SEED;
    end else if (seed_wr) begin
      lfsr_r <= pwdata_i[7:0];
    end else begin
      lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
    end
  end

  // ==========================================================================
  // MII sampling; loopback picks the source ahead of the synchroniser
  wire [5:0] raw_in = rxc1_r[RXC1_LOOP] ? {tx_clk_i, tx_en_i, txd_i}
                                        : {mii_rx_clk_i, mii_rx_dv_i, mii_rxd_i};
  logic [5:0] sync1_r, sync2_r;
  logic clk_d_r;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
      clk_d_r <= 1'b0;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
      clk_d_r <= sync2_r[5];
    end
  end
  wire link_edge = sync2_r[5] & ~clk_d_r;
  wire s_dv = sync2_r[4];
  wire [3:0] s_nib = sync2_r[3:0];

  // ==========================================================================
  // Receive engine
  emrf_state_t st_r;
  logic [3:0] lo_nib_r;
  logic hi_r, byte_stb_r, decide_r, pass_r;
  logic [7:0] byte_r;
  logic [10:0] cnt_r;
  logic [7:0] da_r [6];
  logic [15:0] lt_r;
  logic [31:0] crc_r;
  logic [2:0] replay_r;
  emrf_byte_t pe_byte_r;
  logic pe_valid_r, stat_vld_r, jam_r;
  emrf_status_t stat_r;

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] x;
    x = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction

  wire [47:0] da48 = {da_r[0], da_r[1], da_r[2], da_r[3], da_r[4], da_r[5]};
  wire [47:0] sta48 = {station_r[0], station_r[1], station_r[2],
                       station_r[3], station_r[4], station_r[5]};
  wire [47:0] msk48 = {mask_r[0], mask_r[1], mask_r[2], mask_r[3], mask_r[4], mask_r[5]};
  wire [47:0] mtc48 = {match_r[0], match_r[1], match_r[2],
                       match_r[3], match_r[4], match_r[5]};
  wire filt_en = rxc1_r[RXC1_FILT];
  wire mask_nz = (msk48 != 48'h000000000000);
  wire is_bcast = (da48 == 48'hFFFFFFFFFFFF);
  wire is_group = da48[DA_MSB];
  wire uni_ok = ~filt_en | (da48 == sta48);
  wire grp_ok = ~filt_en | ~mask_nz | ((msk48 & mtc48) == (msk48 & da48));
  wire bc_ok = ~(rxc1_r[RXC1_BC_DIS] & mask_nz & filt_en);
  wire addr_ok = is_bcast ? bc_ok : (is_group ? grp_ok : uni_ok);

  wire is_len = (lt_r <= MAX_LEN);
  wire lt_bad = (lt_r > MAX_LEN) && (lt_r < MIN_TYPE);
  wire padded = is_len && (lt_r < MIN_PAYLOAD);
  wire [10:0] pay_end = HDR_LEN + lt_r[10:0];
  wire in_pad = rxc1_r[RXC1_PADSTRIP] & padded & (cnt_r >= pay_end) & (cnt_r < PAD_END);
  wire live_out = byte_stb_r & pass_r & (cnt_r >= 11'(DA_BYTES)) & ~in_pad;
  wire frame_end = (st_r == ST_DATA) & ~s_dv;
  wire is_runt = (cnt_r < MIN_FRAME) & ~padded;
  wire runt_drop = is_runt & ~rxc1_r[RXC1_RUNT_OK];
  wire fcs_bad = (crc_r != CRC_RESIDUE);
  wire flush_abort = core_r[CORE_RX_FLUSH] & (st_r == ST_DATA);
  wire type_abort = byte_stb_r & pass_r & (cnt_r == 11'h00E) & lt_bad;

  // Nibble to byte assembly, low nibble first
  always_ff @(posedge clk_i) begin
    if (mac_rst) begin
      st_r <= ST_IDLE;
      hi_r <= 1'b0;
      lo_nib_r <= 4'h0;
      byte_r <= 8'h00;
      byte_stb_r <= 1'b0;
      jam_r <= 1'b0;
    end else begin
      byte_stb_r <= 1'b0;
      jam_r <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (rxc1_r[RXC1_EN] && link_edge && s_dv) begin
            st_r <= ST_PRE;
          end
        end
        ST_PRE: begin
          if (link_edge && !s_dv) begin
            st_r <= ST_IDLE;
          end else if (link_edge && s_nib == SFD_NIB) begin
            st_r <= ST_DATA;
            hi_r <= 1'b0;
            jam_r <= core_r[CORE_JAM];
          end
        end
        ST_DATA: begin
          if (frame_end || flush_abort || type_abort || (decide_r && !addr_ok)) begin
            st_r <= frame_end ? ST_IDLE : ST_DROP;
          end else if (link_edge) begin
            hi_r <= ~hi_r;
            lo_nib_r <= s_nib;
            if (hi_r) begin
              byte_r <= {s_nib, lo_nib_r};
              byte_stb_r <= 1'b1;
            end
          end
        end
        ST_DROP: begin
          if (!s_dv) begin
            st_r <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Byte bookkeeping: destination capture, length/type, FCS
  always_ff @(posedge clk_i) begin
    if (mac_rst || st_r == ST_PRE) begin
      cnt_r <= 11'h000;
      crc_r <= CRC_INIT;
      lt_r <= 16'h0000;
      decide_r <= 1'b0;
      pass_r <= 1'b0;
    end else begin
      decide_r <= byte_stb_r && (cnt_r == 11'h005);
      if (decide_r) begin
        pass_r <= addr_ok;
      end
      if (byte_stb_r) begin
        if (cnt_r != 11'h7FF) begin
          cnt_r <= cnt_r + 11'h001;
        end
        crc_r <= crc_byte(crc_r, byte_r); // Pad bytes included
        if (cnt_r < 11'(DA_BYTES)) begin
          da_r[cnt_r[2:0]] <= byte_r;
        end
        if (pass_r && cnt_r == 11'h00C) begin
          lt_r[15:8] <= byte_r;
        end
        if (pass_r && cnt_r == 11'h00D) begin
          lt_r[7:0] <= byte_r;
        end
      end
    end
  end

  // Lengths are judged on lt_r after byte 13; type check runs on byte 14
  // Replay of the held destination, then live bytes; status on every frame
  always_ff @(posedge clk_i) begin
    if (mac_rst) begin
      replay_r <= 3'h0;
      pe_byte_r <= '0;
      pe_valid_r <= 1'b0;
      stat_r <= '0;
      stat_vld_r <= 1'b0;
      last_stat_r <= '0;
    end else begin
      pe_valid_r <= 1'b0;
      stat_vld_r <= 1'b0;
      // Copy one cycle after the pulse, once stat_r holds this frame
      if (stat_vld_r) begin
        last_stat_r <= stat_r;
      end
      if (decide_r && addr_ok && st_r == ST_DATA) begin
        replay_r <= DA_BYTES;
      end else if (replay_r != 3'h0) begin
        replay_r <= replay_r - 3'h1;
        pe_valid_r <= 1'b1;
        pe_byte_r.sof <= (replay_r == DA_BYTES);
        pe_byte_r.data <= da_r[3'(DA_BYTES - replay_r)];
      end else if (live_out && st_r == ST_DATA) begin
        pe_valid_r <= 1'b1;
        pe_byte_r.sof <= 1'b0;
        pe_byte_r.data <= byte_r;
      end
      if (st_r == ST_DATA && (frame_end || flush_abort || type_abort ||
          (decide_r && !addr_ok))) begin
        stat_vld_r <= 1'b1;
        stat_r.addr_drop <= decide_r && !addr_ok;
        stat_r.bad_type <= type_abort;
        stat_r.flushed <= flush_abort;
        stat_r.runt <= frame_end & runt_drop;
        stat_r.fcs_err <= frame_end & fcs_bad;
        stat_r.accept <= frame_end && pass_r && !runt_drop && !fcs_bad;
      end
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = 1'b0;
  assign pe_byte_o = pe_byte_r;
  assign pe_valid_o = pe_valid_r;
  assign pe_status_o = stat_r;
  assign pe_status_vld_o = stat_vld_r;
  assign jam_o = jam_r;
  assign tx_flush_o = tx_flush_r;
  assign rx_flush_o = rx_flush_r;
  assign mac_rst_o = mac_rst_r;
  assign mdc_o = mdc_r;
  assign mdc_oe_o = mdc_oe_r;
  assign xover_sel_o = lfsr_r[7];

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  uni_drop_a: assert property (decide_r && st_r == ST_DATA && filt_en && !is_group &&
      da48 != sta48 |=> st_r == ST_DROP && !pass_r) else $error("unicast mismatch kept");
  grp_match_a: assert property (decide_r && st_r == ST_DATA && filt_en && is_group &&
      !is_bcast && mask_nz && ((msk48 & mtc48) != (msk48 & da48)) |=> st_r == ST_DROP)
      else $error("group mismatch kept");
  mask_zero_a: assert property (decide_r && st_r == ST_DATA && !mask_nz && is_group
      |=> pass_r) else $error("zero mask filtered");
  no_filt_a: assert property (decide_r && st_r == ST_DATA && !filt_en && !is_bcast
      |=> pass_r) else $error("promiscuous frame dropped");
  replay_six_a: assert property (decide_r && addr_ok && st_r == ST_DATA
      |=> ##1 pe_valid_o [*6]) else $error("destination replay short");
  rx_off_a: assert property (st_r == ST_IDLE && !rxc1_r[RXC1_EN] |=> st_r == ST_IDLE)
      else $error("receiver started while off");
  jam_cause_a: assert property (jam_o |-> $past(core_r[CORE_JAM]) &&
      $past(st_r) == ST_PRE) else $error("jam without cause");
  mdc_dir_a: assert property (mdc_oe_o == $past(core_r[CORE_MDC_DRV]))
      else $error("mdc direction wrong");
  mac_hold_a: assert property (core_r[CORE_MAC_RST] |=> st_r == ST_IDLE && !pe_valid_o)
      else $error("mac active in reset");
  stat_end_a: assert property ($fell(s_dv) && st_r == ST_DATA |-> ##[1:3] pe_status_vld_o)
      else $error("status missing at frame end");
  accept_c: cover property (pe_status_vld_o && pe_status_o.accept);
  drop_c: cover property (pe_status_vld_o && pe_status_o.addr_drop);
  fcs_c: cover property (pe_status_vld_o && pe_status_o.fcs_err);
  loop_c: cover property (rxc1_r[RXC1_LOOP] && pe_valid_o && pe_byte_o.sof);
endmodule : emrf_rx_filter

// File: verif/emrf_phy_model.sv
// PHY receive-side model: sends one MII frame of nibbles when asked.
// Assumes the bench fills fr[] and calls send() from its main process.
`timescale 1ns/100ps
module emrf_phy_model (
  output logic rx_clk_o, // Receive clock, still between frames
  output logic rx_dv_o, // Receive data valid
  output logic [3:0] rxd_o // Receive nibble
);
  logic [7:0] fr [0:63];
  initial begin
    rx_clk_o = 1'b0;
    rx_dv_o = 1'b0;
    rxd_o = 4'hA;
  end
  // One nibble per 125 ns, data changed on the falling edge
  task automatic nib(input logic [3:0] n);
    rxd_o = n;
    #62.5 rx_clk_o = 1'b1;
    #62.5 rx_clk_o = 1'b0;
  endtask : nib
  task automatic send(input int n);
    // Fractional offset keeps link edges off the system clock edges
    #0.3 rx_dv_o = 1'b1;
    for (int i = 0; i < 15; i++) nib(4'h5);
    nib(4'hD);
    for (int i = 0; i < n; i++) begin
      nib(fr[i][3:0]);
      nib(fr[i][7:4]);
    end
    rx_dv_o = 1'b0;
    // Released data line must not keep the last value
    rxd_o = ~rxd_o;
  endtask : send
endmodule : emrf_phy_model

// File: verif/tb_top.sv
// Bench for the receive filter: APB register access and MII frames.
// Assumes the PHY model is compiled first; a second model drives the loopback inputs.
`timescale 1ns/100ps
module tb_top;
  import emrf_pkg::*;
  logic clk_i, srst_i, psel, pen, pw, pready, pslverr, mdc_oe, txf, rxf, mrst;
  logic jam, pe_valid, st_vld, rclk, rdv, tclk, tdv, xsel, mdc;
  logic [3:0] txd;
  logic [7:0] sofb;
  emrf_byte_t pb;
  logic [11:0] pa;
  logic [31:0] pd, prd, q;
  logic [3:0] rxd;
  emrf_status_t st;
  int fails = 0, n_tests = 0, nb = 0, nst = 0, njam = 0;
  emrf_phy_model phy (.rx_clk_o(rclk), .rx_dv_o(rdv), .rxd_o(rxd));
  // Second model stands in for the transmit side seen through loopback
  emrf_phy_model txm (.rx_clk_o(tclk), .rx_dv_o(tdv), .rxd_o(txd));
  emrf_rx_filter #(.MDC_DIV_P(2)) dut (.clk_i(clk_i), .srst_i(srst_i),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pw), .paddr_i(pa), .pwdata_i(pd),
    .prdata_o(prd), .pready_o(pready), .pslverr_o(pslverr), .mii_rx_clk_i(rclk),
    .mii_rx_dv_i(rdv), .mii_rxd_i(rxd), .tx_clk_i(tclk), .tx_en_i(tdv),
    .txd_i(txd), .pe_byte_o(pb), .pe_valid_o(pe_valid), .pe_status_o(st),
    .pe_status_vld_o(st_vld), .jam_o(jam), .tx_flush_o(txf), .rx_flush_o(rxf),
    .mac_rst_o(mrst), .mdc_o(mdc), .mdc_oe_o(mdc_oe), .xover_sel_o(xsel));
  // ==========================================================================
  // Clock, monitors and shared tasks
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (pe_valid === 1'b1) nb <= nb + 1;
    if (pe_valid === 1'b1 && pb.sof === 1'b1) sofb <= pb.data;
    if (st_vld === 1'b1) nst <= nst + 1;
    if (jam === 1'b1) njam <= njam + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pen <= 1'b0;
    pw <= w;
    pa <= a;
    pd <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'b1);
    chk(32'(k), 32'h1);
    q = prd;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk_i);
  endtask : apb
  task automatic wr6(input logic [11:0] b, input logic [47:0] v);
    for (int i = 0; i < 6; i++) apb(1'b1, b + 12'(4 * i), {24'h0, v[47 - 8 * i -: 8]});
  endtask : wr6
  task automatic frame(input logic [47:0] da, input logic bad, input logic [5:0] es,
                       input int en, input logic [15:0] lt = 16'h0C0D, input int len = 64,
                       input logic lp = 1'b0);
    logic [31:0] c;
    int k;
    for (int i = 0; i < 64; i++) phy.fr[i] = (i < 6) ? da[47 - 8 * i -: 8] : 8'(i);
    phy.fr[12] = lt[15:8];
    phy.fr[13] = lt[7:0];
    c = CRC_INIT;
    for (int i = 0; i < len - 4; i++) begin
      c ^= 32'(phy.fr[i]);
      for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    // Bad flag flips one FCS bit
    c = ~c ^ 32'(bad);
    for (int i = 0; i < 4; i++) phy.fr[len - 4 + i] = c[8 * i +: 8];
    nb = 0;
    nst = 0;
    njam = 0;
    if (lp) begin
      txm.fr = phy.fr;
      txm.send(len);
    end else begin
      phy.send(len);
    end
    k = 0;
    while (nst == 0 && k < 40) begin
      @(posedge clk_i);
      k++;
    end
    @(posedge clk_i);
    chk(32'(nst), (es == 6'h00) ? 32'h0 : 32'h1);
    if (nst != 0) chk(32'(st), 32'(es));
    chk(32'(nb), 32'(en));
    if (en != 0) chk(32'(sofb), 32'(da[47:40]));
  endtask : frame
  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    apb(1'b0, OFF_THRESH, 32'h0);
    chk(q, 32'h1);
    apb(1'b1, OFF_THRESH, 32'h1);
    apb(1'b1, OFF_RXC2, 32'h0);
    apb(1'b1, OFF_SEED, 32'hA5);
    chk(32'(xsel), 32'h1);
    apb(1'b0, OFF_SEED, 32'h0);
    chk(q, 32'hA5);
    apb(1'b1, 12'h300, 32'hFF);
    apb(1'b0, 12'h300, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, pslverr}, 32'h0);
  endtask : t_regs
  task automatic t_core;
    int k;
    logic m;
    // Control levels trail the register by one cycle
    for (int b = 0; b < 5; b++) if (b != 3) begin
      apb(1'b1, OFF_CORE, 32'(1 << b));
      @(posedge clk_i);
      chk(32'({mdc_oe, txf, rxf, mrst}), 32'(b == 4 ? 8 : 1 << b));
    end
    apb(1'b1, OFF_CORE, 32'h0);
    @(posedge clk_i);
    chk(32'({mdc_oe, txf, rxf, mrst}), 32'h0);
    k = 0;
    m = mdc;
    repeat (8) begin
      @(posedge clk_i);
      if (mdc !== m) k++;
      m = mdc;
    end
    chk(32'(k), 32'h4);
  endtask : t_core
  task automatic t_frames;
    wr6(OFF_STATION, 48'h021122334455);
    frame(48'h021122334455, 1'b0, 6'h00, 0);
    apb(1'b1, OFF_RXC1, 32'h21);
    frame(48'h021122334455, 1'b0, 6'h20, 64);
    frame(48'h021122334456, 1'b0, 6'h10, 0);
    frame(48'h021122334455, 1'b1, 6'h02, 64);
    apb(1'b1, OFF_RXC1, 32'h01);
    frame(48'h021122334456, 1'b0, 6'h20, 64);
    wr6(OFF_MASK, 48'h00FFFF000000);
    wr6(OFF_MATCH, 48'h00C1D2387200);
    apb(1'b1, OFF_RXC1, 32'h21);
    frame(48'hA1C1D2476321, 1'b0, 6'h20, 64);
    frame(48'hA1C1D3476321, 1'b0, 6'h10, 0);
    frame(48'hFFFFFFFFFFFF, 1'b0, 6'h20, 64);
    apb(1'b1, OFF_RXC1, 32'hA1);
    frame(48'hFFFFFFFFFFFF, 1'b0, 6'h10, 0);
    wr6(OFF_MASK, 48'h0);
    frame(48'hA1C1D3476321, 1'b0, 6'h20, 64);
    chk(32'(njam), 32'h0);
    apb(1'b1, OFF_CORE, 32'h08);
    frame(48'h021122334455, 1'b0, 6'h20, 64);
    chk(32'(njam), 32'h1);
  endtask : t_frames
  task automatic t_len;
    apb(1'b1, OFF_RXC1, 32'h21);
    frame(48'h021122334455, 1'b0, 6'h20, 64, 16'h0010);
    apb(1'b1, OFF_RXC1, 32'h23);
    frame(48'h021122334455, 1'b0, 6'h20, 34, 16'h0010);
    frame(48'h021122334455, 1'b0, 6'h04, 15, 16'h05FF);
    frame(48'h021122334455, 1'b0, 6'h08, 40, 16'h0C0D, 40);
    apb(1'b0, OFF_RXSTAT, 32'h0);
    chk(q, 32'h08);
    apb(1'b1, OFF_RXC1, 32'h61);
    frame(48'h021122334455, 1'b0, 6'h20, 40, 16'h0C0D, 40);
    apb(1'b1, OFF_RXC1, 32'h31);
    frame(48'h021122334455, 1'b0, 6'h00, 0);
    frame(48'h021122334455, 1'b0, 6'h20, 64, 16'h0C0D, 64, 1'b1);
  endtask : t_len
  task automatic give_verdict;
    $display("Counts: %0d compares, %0d mismatches", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  initial begin
    srst_i = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pw = 1'b0;
    pa = 12'h000;
    pd = 32'h0;
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    t_regs;
    t_core;
    t_frames;
    t_len;
    give_verdict;
  end
  // 64-byte frames take about 18 us each, 40-byte ones 12 us; this bound is just under twice the run
  initial begin
    #600000;
    fails++;
    give_verdict;
  end
endmodule : tb_top
